// ==== src/rhp_port_state.sv ====
/*
  Root hub downstream port state bits for one port, with an AXI4-Lite slave
  holding the port state word and a port control word.
  Assumes port pins (attach, overcurrent, power, bus error, remote resume)
  are synchronous to aclk.
*/
// Added by the designer: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module rhp_port_state import rhp_pkg::*; #(
  parameter int unsigned RESET_LEN = RESET_CYCLES, // port reset interval, cycles
  parameter int unsigned RESUME_LEN = RESUME_CYCLES // resume interval, cycles
) (
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset, active low
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte enables
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic dev_attached, // device present on the port
  input wire logic overcurrent, // port overcurrent level
  input wire logic port_power_on, // port power switched on
  input wire logic bus_error, // operational bus error pulse
  input wire logic remote_resume, // resume signalled by the device
  output logic port_reset_drive, // drive reset signalling
  output logic port_resume_drive, // drive resume signalling
  output logic port_enabled, // port enabled
  output logic port_suspended, // port suspended
  output logic resume_to_hc // pulse: device resume to controller
);
  logic aw_held_reg, aw_held_next;
  logic w_held_reg, w_held_next;
  logic [ADDR_W-1:0] awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic awready_reg, awready_next;
  logic wready_reg, wready_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic arready_reg, arready_next;
  logic rvalid_reg, rvalid_next;
  logic [1:0] rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  rhp_seq_t seq_reg, seq_next;
  logic en_reg, en_next;
  logic susp_reg, susp_next;
  logic rst_act_reg, rst_act_next;
  logic conn_chg_reg, conn_chg_next;
  logic en_chg_reg, en_chg_next;
  logic susp_chg_reg, susp_chg_next;
  logic rst_chg_reg, rst_chg_next;
  logic att_prev_reg, att_prev_next;
  logic fixed_mask_reg, fixed_mask_next;
  logic [1:0] hc_state_reg, hc_state_next;
  logic resume_hc_reg, resume_hc_next;
  logic resume_drv_reg, resume_drv_next;
  logic attached;
  logic wr_fire, wr_state, wr_ctrl;
  logic s_clr_en, s_set_en, s_set_susp, s_resume, s_reset;
  logic tmr_start, tmr_abort, tmr_done;
  logic [TMR_W-1:0] tmr_len;
  logic [31:0] state_word, ctrl_word;
  rhp_interval_timer u_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(tmr_start),
    .abort(tmr_abort),
    .length(tmr_len),
    .done(tmr_done)
  );
  always_comb begin
    attached = dev_attached | fixed_mask_reg;
    state_word = '0;
    state_word[ATTACHED_BIT] = attached;
    state_word[ENABLED_BIT] = en_reg;
    state_word[SUSPENDED_BIT] = susp_reg;
    state_word[RESET_BIT] = rst_act_reg;
    state_word[CONN_CHG_BIT] = conn_chg_reg;
    state_word[EN_CHG_BIT] = en_chg_reg;
    state_word[SUSP_CHG_BIT] = susp_chg_reg;
    state_word[RESET_CHG_BIT] = rst_chg_reg;
    ctrl_word = '0;
    ctrl_word[FIXED_MASK_BIT] = fixed_mask_reg;
    ctrl_word[HC_STATE_LSB +: 2] = hc_state_reg;
  end
  // bus slave: address and data accepted in either order
  always_comb begin
    aw_held_next = aw_held_reg;
    w_held_next = w_held_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    arready_next = arready_reg;
    rvalid_next = rvalid_reg;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    wr_fire = aw_held_reg & w_held_reg & ~bvalid_reg;
    wr_state = wr_fire & (awaddr_reg[ADDR_W-1:2] == STATE_WORD_OFF[ADDR_W-1:2]);
    wr_ctrl = wr_fire & (awaddr_reg[ADDR_W-1:2] == CTRL_OFF[ADDR_W-1:2]);
    if (s_axi_awvalid && awready_reg) begin
      aw_held_next = 1'b1;
      awaddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_reg) begin
      w_held_next = 1'b1;
      wdata_next = s_axi_wdata;
      wstrb_next = s_axi_wstrb;
    end
    if (wr_fire) begin
      aw_held_next = 1'b0;
      w_held_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = (wr_state | wr_ctrl) ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    awready_next = ~aw_held_next & ~bvalid_next;
    wready_next = ~w_held_next & ~bvalid_next;
    if (s_axi_arvalid && arready_reg) begin
      arready_next = 1'b0;
      rvalid_next = 1'b1;
      if (s_axi_araddr[ADDR_W-1:2] == STATE_WORD_OFF[ADDR_W-1:2]) begin
        rdata_next = state_word;
        rresp_next = RESP_OKAY;
      end else if (s_axi_araddr[ADDR_W-1:2] == CTRL_OFF[ADDR_W-1:2]) begin
        rdata_next = ctrl_word;
        rresp_next = RESP_OKAY;
      end else begin
        rdata_next = '0;
        rresp_next = RESP_SLVERR;
      end
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
      arready_next = 1'b1;
    end
  end
  always_comb begin
    seq_next = seq_reg;
    en_next = en_reg;
    susp_next = susp_reg;
    rst_act_next = rst_act_reg;
    conn_chg_next = conn_chg_reg;
    en_chg_next = en_chg_reg;
    susp_chg_next = susp_chg_reg;
    rst_chg_next = rst_chg_reg;
    fixed_mask_next = fixed_mask_reg;
    hc_state_next = hc_state_reg;
    att_prev_next = attached;
    resume_hc_next = 1'b0;
    tmr_start = 1'b0;
    tmr_abort = 1'b0;
    tmr_len = TMR_W'(RESET_LEN);
    s_clr_en = wr_state & wstrb_reg[0] & wdata_reg[ATTACHED_BIT];
    s_set_en = wr_state & wstrb_reg[0] & wdata_reg[ENABLED_BIT];
    s_set_susp = wr_state & wstrb_reg[0] & wdata_reg[SUSPENDED_BIT];
    s_resume = wr_state & wstrb_reg[0] & wdata_reg[RESUME_BIT];
    s_reset = wr_state & wstrb_reg[0] & wdata_reg[RESET_BIT];
    // change flags clear first so a same-cycle event wins
    if (wr_state && wstrb_reg[2]) begin
      if (wdata_reg[CONN_CHG_BIT]) conn_chg_next = 1'b0;
      if (wdata_reg[EN_CHG_BIT]) en_chg_next = 1'b0;
      if (wdata_reg[SUSP_CHG_BIT]) susp_chg_next = 1'b0;
      if (wdata_reg[RESET_CHG_BIT]) rst_chg_next = 1'b0;
    end
    if (wr_ctrl && wstrb_reg[0]) begin
      fixed_mask_next = wdata_reg[FIXED_MASK_BIT];
      hc_state_next = wdata_reg[HC_STATE_LSB +: 2];
    end
    if (attached != att_prev_reg) conn_chg_next = 1'b1;
    if (tmr_done) begin
      unique case (seq_reg)
        SEQ_RESETTING: begin
          rst_act_next = 1'b0;
          rst_chg_next = 1'b1;
          susp_next = 1'b0;
          en_next = 1'b1;
          seq_next = SEQ_IDLE;
        end
        SEQ_RESUMING: begin
          susp_next = 1'b0;
          susp_chg_next = 1'b1;
          en_next = 1'b1;
          seq_next = SEQ_IDLE;
        end
        SEQ_IDLE, SEQ_SUSPENDED: ;
      endcase
    end
    if (s_clr_en) en_next = 1'b0;
    if (s_set_en) begin
      if (attached) en_next = 1'b1;
      else conn_chg_next = 1'b1;
    end
    if (s_set_susp) begin
      if (!attached) begin
        conn_chg_next = 1'b1;
      end else if (seq_reg == SEQ_IDLE) begin
        susp_next = 1'b1;
        seq_next = SEQ_SUSPENDED;
      end
    end
    if (seq_reg == SEQ_SUSPENDED && susp_reg && (s_resume || remote_resume)) begin
      seq_next = SEQ_RESUMING;
      tmr_start = 1'b1;
      tmr_len = TMR_W'(RESUME_LEN);
      resume_hc_next = remote_resume & ~s_resume;
    end
    if (s_reset) begin
      if (attached) begin
        rst_act_next = 1'b1;
        seq_next = SEQ_RESETTING;
        tmr_start = 1'b1;
        tmr_len = TMR_W'(RESET_LEN);
      end else begin
        conn_chg_next = 1'b1;
      end
    end
    if (hc_state_reg == HC_STATE_RESUME && seq_next != SEQ_RESETTING) begin
      susp_next = 1'b0;
      if (seq_reg == SEQ_RESUMING) tmr_abort = 1'b1;
      seq_next = SEQ_IDLE;
    end
    if (!attached) begin
      // disconnect ends any signalling in flight
      tmr_abort = 1'b1;
      tmr_start = 1'b0;
      seq_next = SEQ_IDLE;
      susp_next = 1'b0;
      rst_act_next = 1'b0;
    end
    if (overcurrent || !attached || !port_power_on || bus_error) begin
      en_next = 1'b0;
      if (en_reg) en_chg_next = 1'b1;
    end
    resume_drv_next = (seq_next == SEQ_RESUMING);
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= '0;
      seq_reg <= SEQ_IDLE;
      en_reg <= 1'b0;
      susp_reg <= 1'b0;
      rst_act_reg <= 1'b0;
      conn_chg_reg <= 1'b0;
      en_chg_reg <= 1'b0;
      susp_chg_reg <= 1'b0;
      rst_chg_reg <= 1'b0;
      att_prev_reg <= 1'b0;
      fixed_mask_reg <= FIXED_MASK_RST;
      hc_state_reg <= HC_STATE_RST;
      resume_hc_reg <= 1'b0;
      resume_drv_reg <= 1'b0;
    end else begin
      aw_held_reg <= aw_held_next;
      w_held_reg <= w_held_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      arready_reg <= (arready_next | (~arready_reg & ~rvalid_reg & ~rvalid_next));
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
      seq_reg <= seq_next;
      en_reg <= en_next;
      susp_reg <= susp_next;
      rst_act_reg <= rst_act_next;
      conn_chg_reg <= conn_chg_next;
      en_chg_reg <= en_chg_next;
      susp_chg_reg <= susp_chg_next;
      rst_chg_reg <= rst_chg_next;
      att_prev_reg <= att_prev_next;
      fixed_mask_reg <= fixed_mask_next;
      hc_state_reg <= hc_state_next;
      resume_hc_reg <= resume_hc_next;
      resume_drv_reg <= resume_drv_next;
    end
  end
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;
  assign port_reset_drive = rst_act_reg;
  assign port_resume_drive = resume_drv_reg;
  assign port_enabled = en_reg;
  assign port_suspended = susp_reg;
  assign resume_to_hc = resume_hc_reg;
endmodule
`default_nettype wire

// ==== src/rhp_pkg.sv ====
/*
  Shared constants for the root port state logic: register offsets, bit
  positions, reset values, interval timing and the sequencer state type.
  Assumes a 100 MHz host controller clock.
*/
package rhp_pkg;
  localparam int CLK_MHZ = 100;
  localparam int RESET_TIME_MS = 10;
  localparam int RESUME_TIME_MS = 20;
  localparam int RESET_CYCLES = RESET_TIME_MS * 1000 * CLK_MHZ;
  localparam int RESUME_CYCLES = RESUME_TIME_MS * 1000 * CLK_MHZ;
  localparam int TMR_W = 24;

  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] STATE_WORD_OFF = 12'h000;
  localparam logic [ADDR_W-1:0] CTRL_OFF = 12'h004;

  // root_port_state_word, read meaning / write strobe
  localparam int ATTACHED_BIT = 0;
  localparam int ENABLED_BIT = 1;
  localparam int SUSPENDED_BIT = 2;
  localparam int RESUME_BIT = 3;
  localparam int RESET_BIT = 4;
  localparam int CONN_CHG_BIT = 16;
  localparam int EN_CHG_BIT = 17;
  localparam int SUSP_CHG_BIT = 18;
  localparam int RESET_CHG_BIT = 20;

  // port control word
  localparam int FIXED_MASK_BIT = 0;
  localparam int HC_STATE_LSB = 2;
  localparam logic [1:0] HC_STATE_RST = 2'h0;
  localparam logic [1:0] HC_STATE_RESUME = 2'h1;
  localparam logic FIXED_MASK_RST = 1'b0;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_SUSPENDED = 2'b01,
    SEQ_RESUMING = 2'b11,
    SEQ_RESETTING = 2'b10
  } rhp_seq_t;
endpackage

// ==== src/rhp_interval_timer.sv ====
/*
  Down counter that times one port signalling interval and pulses done.
  Assumes start is a single-cycle request from the port logic; abort is held every cycle the port is detached.
*/
`timescale 1ns/1ps
`default_nettype none
module rhp_interval_timer import rhp_pkg::*; (
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset, active low
  input wire logic start, // load length and run
  input wire logic abort, // stop without done
  input wire logic [TMR_W-1:0] length, // interval in cycles
  output logic done // one-cycle pulse at expiry
);
  logic [TMR_W-1:0] cnt_reg, cnt_next;
  logic run_reg, run_next;
  logic done_reg, done_next;

  always_comb begin
    cnt_next = cnt_reg;
    run_next = run_reg;
    done_next = 1'b0;
    if (start) begin
      cnt_next = length;
      run_next = 1'b1;
    end else if (abort) begin
      run_next = 1'b0;
    end else if (run_reg) begin
      if (cnt_reg <= TMR_W'(1)) begin
        run_next = 1'b0;
        done_next = 1'b1;
      end else begin
        cnt_next = cnt_reg - TMR_W'(1);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= '0;
      run_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      run_reg <= run_next;
      done_reg <= done_next;
    end
  end

  assign done = done_reg;
endmodule
`default_nettype wire

// ==== bench/rhp_port_state_asserts.sv ====
/*
  Checker for rhp_port_state: timing and flag relations at the top ports.
  Assumes one clock aclk and synchronous active-low aresetn.
*/
`timescale 1ns/1ps
`default_nettype none
module rhp_port_state_chk import rhp_pkg::*; #(
  parameter int unsigned RESET_LEN = 20, // reset interval
  parameter int unsigned RESUME_LEN = 30 // resume interval
) (
  input wire logic aclk, // clock
  input wire logic aresetn, // reset
  input wire logic [ADDR_W-1:0] s_axi_araddr, // read addr
  input wire logic s_axi_arvalid, // ar valid
  input wire logic s_axi_arready, // ar ready
  input wire logic [31:0] s_axi_rdata, // read data
  input wire logic dev_attached, // attach
  input wire logic overcurrent, // overcurrent
  input wire logic port_power_on, // power
  input wire logic bus_error, // bus error
  input wire logic remote_resume, // device wake
  input wire logic port_reset_drive, // reset active
  input wire logic port_resume_drive, // resume active
  input wire logic port_enabled, // enabled
  input wire logic port_suspended, // suspended
  input wire logic resume_to_hc // wake pulse
);
  int cnt_reg;
  int cnt_next;
  // cycles spent in the current reset or resume interval
  always_comb begin
    cnt_next = (port_reset_drive || port_resume_drive) ? cnt_reg + 1 : 0;
    if (!aresetn) begin
      cnt_next = 0;
    end
  end
  always_ff @(posedge aclk) begin
    cnt_reg <= cnt_next;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_rd_state;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == STATE_WORD_OFF;
  endsequence
  sequence s_reset_end;
    $fell(port_reset_drive) && $past(dev_attached && port_power_on && !overcurrent && !bus_error);
  endsequence
  sequence s_wake;
    $rose(remote_resume) && port_suspended && !port_resume_drive && !port_reset_drive;
  endsequence
  chk_susp_in_resume: assert property (port_resume_drive |-> port_suspended)
    else $error("suspended low during resume");
  chk_wake_pulse: assert property (s_wake |=> resume_to_hc ##1 !resume_to_hc)
    else $error("no single wake pulse");
  chk_wake_cause: assert property ($rose(resume_to_hc) |-> $past(port_suspended))
    else $error("wake pulse without suspend");
  chk_resume_start: assert property ($rose(port_resume_drive) |-> $past(port_suspended))
    else $error("resume on unsuspended port");
  chk_resume_end: assert property ($fell(port_resume_drive) |-> !port_suspended)
    else $error("suspend kept after resume");
  chk_reset_end: assert property (s_reset_end |-> port_enabled && !port_suspended
    && $past(cnt_reg) >= RESET_LEN - 2)
    else $error("bad reset completion");
  chk_reset_len: assert property (port_reset_drive |-> cnt_reg <= RESET_LEN + 1)
    else $error("reset too long");
  chk_resume_len: assert property (port_resume_drive |-> cnt_reg <= RESUME_LEN + 1)
    else $error("resume too long");
  chk_en_attached: assert property ($rose(port_enabled) |-> $past(dev_attached))
    else $error("enabled while detached");
  chk_susp_attached: assert property ($rose(port_suspended) |-> $past(dev_attached))
    else $error("suspended while detached");
  chk_fault_off: assert property ((overcurrent || !port_power_on || bus_error || !dev_attached)
    |=> !port_enabled)
    else $error("enabled during fault");
  chk_attach_read: assert property (s_rd_state ##0 dev_attached |=> s_axi_rdata[ATTACHED_BIT])
    else $error("attach bit low");
endmodule
bind rhp_port_state rhp_port_state_chk #(.RESET_LEN(RESET_LEN), .RESUME_LEN(RESUME_LEN)) u_chk (
  .aclk, .aresetn, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .dev_attached,
  .overcurrent, .port_power_on, .bus_error, .remote_resume, .port_reset_drive, .port_resume_drive,
  .port_enabled, .port_suspended, .resume_to_hc);
`default_nettype wire

// ==== bench/rhp_usb_dev.sv ====
/*
  Model of the USB device on the downstream port: attach level and wake.
  Assumes the bench plugs it and asks for wake; runs on aclk.
*/
`timescale 1ns/1ps
`default_nettype none
module rhp_usb_dev (
  input wire logic aclk, // clock
  input wire logic plug, // device plugged
  input wire logic wake, // device wants wake
  input wire logic port_suspended, // port suspended
  output logic dev_attached, // attach level
  output logic remote_resume // wake signalling
);
  // a device may only signal wake on a suspended port
  always_ff @(posedge aclk) begin
    dev_attached <= plug;
    remote_resume <= plug && wake && port_suspended;
  end
endmodule
`default_nettype wire

// ==== bench/rhp_port_state_bench.sv ====
/*
  Self-checking bench for rhp_port_state over AXI4-Lite with a device model.
  Assumes short interval parameters so runs stay brief.
*/
`timescale 1ns/1ps
`default_nettype none
module rhp_port_state_bench import rhp_pkg::*;;
  localparam int unsigned RST_L = 20;
  localparam int unsigned RSM_L = 30;
  localparam logic [31:0] B_ATT = 32'h1 << ATTACHED_BIT;
  localparam logic [31:0] B_EN = 32'h1 << ENABLED_BIT;
  localparam logic [31:0] B_SU = 32'h1 << SUSPENDED_BIT;
  localparam logic [31:0] B_RM = 32'h1 << RESUME_BIT;
  localparam logic [31:0] B_RS = 32'h1 << RESET_BIT;
  localparam logic [31:0] B_CC = 32'h1 << CONN_CHG_BIT;
  localparam logic [31:0] B_EC = 32'h1 << EN_CHG_BIT;
  localparam logic [31:0] B_SC = 32'h1 << SUSP_CHG_BIT;
  localparam logic [31:0] B_RC = 32'h1 << RESET_CHG_BIT;
  localparam logic [31:0] CHG = B_CC | B_EC | B_SC | B_RC;
  logic aclk = '0;
  logic aresetn = '0;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, rdat, d;
  logic awvalid = '0, wvalid = '0, bready = '0, arvalid = '0, rready = '0;
  logic awready, wready, bvalid, arready, rvalid, e;
  logic [1:0] bresp, rresp, resp;
  logic ovc = '0, pwr = 1'h1, berr = '0, plug = '0, wake = '0;
  logic att, rwake, rst_drv, rsm_drv, en, susp, to_hc;
  int error_cnt = 0;
  int tests_run = 0;
  int n;
  always #5 aclk = ~aclk;
  rhp_usb_dev u_rhp_usb_dev (.aclk(aclk), .plug(plug), .wake(wake), .port_suspended(susp),
    .dev_attached(att), .remote_resume(rwake));
  rhp_port_state #(.RESET_LEN(RST_L), .RESUME_LEN(RSM_L)) u_rhp_port_state (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .dev_attached(att),
    .overcurrent(ovc), .port_power_on(pwr), .bus_error(berr), .remote_resume(rwake),
    .port_reset_drive(rst_drv), .port_resume_drive(rsm_drv), .port_enabled(en),
    .port_suspended(susp), .resume_to_hc(to_hc));
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    tests_run++;
    if (s !== x) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge aclk);
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] v);
    logic pa, pw;
    pa = 1'h1;
    pw = 1'h1;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (pa || pw) begin
      @(posedge aclk);
      if (pa && awready === 1'h1) begin
        pa = 1'h0;
        awvalid <= 1'h0;
      end
      if (pw && wready === 1'h1) begin
        pw = 1'h0;
        wvalid <= 1'h0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'h1);
    resp = bresp;
    bready <= 1'h0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge aclk); while (arready !== 1'h1);
    arvalid <= 1'h0;
    do @(posedge aclk); while (rvalid !== 1'h1);
    rdat = rdata;
    resp = rresp;
    rready <= 1'h0;
    @(posedge aclk);
  endtask
  task automatic rs(input logic [31:0] m, input logic [31:0] x);
    rd(STATE_WORD_OFF);
    chk(rdat & m, x);
  endtask
  // enable after a random strobe pattern, clear taking effect over set
  function automatic logic nxt_en(input logic p, input logic [1:0] s);
    return s[0] ? 1'h0 : (s[1] ? 1'h1 : p);
  endfunction
  initial begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    test_done();
  end
  initial begin
    void'($urandom(32'h4830));
    tick(6);
    aresetn <= 1'h1;
    tick(2);
    rs(32'hFFFF_FFFF, 32'h0);
    rd(12'h010);
    chk(32'(resp), 32'(RESP_SLVERR));
    wr(12'h0FC, B_EN);
    chk(32'(resp), 32'(RESP_SLVERR));
    wr(STATE_WORD_OFF, B_EN);
    rs(B_EN | B_CC, B_CC);
    wr(STATE_WORD_OFF, CHG | B_SU);
    rs(B_SU | B_CC, B_CC);
    wr(CTRL_OFF, 32'h1 << FIXED_MASK_BIT);
    rs(B_ATT, B_ATT);
    wr(CTRL_OFF, 32'h0);
    plug <= 1'h1;
    tick(3);
    rs(B_ATT | B_CC, B_ATT | B_CC);
    rs(B_CC, B_CC);
    wr(STATE_WORD_OFF, CHG);
    wr(STATE_WORD_OFF, 32'h0);
    rs(32'hFFFF_FFFF, B_ATT);
    wr(STATE_WORD_OFF, B_EN);
    tick(1);
    chk(32'(en), 32'h1);
    wr(STATE_WORD_OFF, B_ATT);
    rs(B_ATT | B_EN, B_ATT);
    e = 1'h0;
    repeat (24) begin
      d = $urandom & 32'hFFFF_FF03;
      if (d[1:0] == 2'h3) d[0] = 1'h0;
      e = nxt_en(e, d[1:0]);
      wr(STATE_WORD_OFF, d);
      rs(B_EN | B_ATT, (32'(e) << ENABLED_BIT) | B_ATT);
    end
    wr(STATE_WORD_OFF, CHG | B_SU);
    tick(1);
    chk(32'(susp), 32'h1);
    wr(STATE_WORD_OFF, B_RS);
    chk(32'(rst_drv), 32'h1);
    rs(B_RS | B_SU, B_RS | B_SU);
    tick(RST_L + 4);
    rs(B_RS | B_SU | B_EN | B_RC, B_EN | B_RC);
    wr(STATE_WORD_OFF, CHG | B_ATT);
    wr(STATE_WORD_OFF, B_RM);
    tick(1);
    chk(32'(rsm_drv), 32'h0);
    wr(STATE_WORD_OFF, B_SU);
    wr(STATE_WORD_OFF, B_RM);
    tick(1);
    chk(32'({rsm_drv, susp}), 32'h3);
    tick(RSM_L + 4);
    rs(B_SU | B_EN | B_SC, B_EN | B_SC);
    wr(STATE_WORD_OFF, CHG | B_SU);
    wake <= 1'h1;
    n = 0;
    repeat (8) begin
      @(posedge aclk);
      n += int'(to_hc);
    end
    chk(32'(n), 32'h1);
    wake <= 1'h0;
    tick(RSM_L + 4);
    rs(B_SU | B_SC, B_SC);
    wr(STATE_WORD_OFF, CHG | B_SU);
    wr(CTRL_OFF, 32'(HC_STATE_RESUME) << HC_STATE_LSB);
    rs(B_SU, 32'h0);
    wr(CTRL_OFF, 32'h0);
    for (int i = 0; i < 4; i++) begin
      wr(STATE_WORD_OFF, CHG | B_EN);
      tick(2);
      ovc <= (i == 0);
      pwr <= (i != 1);
      berr <= (i == 2);
      plug <= (i != 3);
      tick(3);
      chk(32'(en), 32'h0);
      ovc <= 1'h0;
      pwr <= 1'h1;
      berr <= 1'h0;
      plug <= 1'h1;
      tick(3);
      rs(B_EN | B_EC, B_EC);
    end
    test_done();
  end
endmodule
`default_nettype wire
